// file: ckc_clock_ctrl.sv
`timescale 1ns/1ns
//
// Behaviour
// [R1] software keeps core clock at least bus clock
// [R2] variant one core/fast 120, medium 60 MHz
// [R3] variant two core 200, fast 100, medium 50
// [R4] usb domain clock exactly 48 MHz
// [R5] software enables trim when fast osc feeds PLL
// [R6] usb needs listed main oscillator frequencies
// [R7] variant one usb ratio from second divider register
// [R8] variant two usb ratio from usb divider register
// [R9] variant one ethernet clock equals core, bounded
// [R10] variant two ethernet clock 12.5 to 100 MHz
// [R11] flash clock at least 4 MHz when programming
// [R12] sdram clock derived from bus clock
// [R13] sdram clock never above core clock
// [R14] wait 750 ns before raising a ratio
// [R15] wait 250 ns after lowering a ratio; a write that also raises a ratio gets only the 750 ns wait before it
// [R16] wait 750 ns before leaving the PLL
// [R17] wait 250 ns after switching to PLL
// [R18] software times waits by counting instructions
// [R19] each oscillator has own start/stop register
// [R20] software idles unused dividers and oscillators
// [R21] fast oscillator selects 16, 18 or 20 MHz
// [R22] fast oscillator may be the PLL reference
// [R23] reset runs system clock from mid oscillator
// [R24] main oscillator and PLL off after reset
// [R25] sequencer holds change and reports busy; a change that needs only the 250 ns wait is applied at once
module ckc_clock_ctrl import ckc_pkg::*; #(
    parameter int VARIANT = 1,
    parameter bit FAST_OSC_RESET_ON = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata_q,
    output logic [31:0] sys_div_q,
    output logic [3:0] usb_div_q,
    output logic [3:0] sdram_div_q,
    output logic sdram_out_en_q,
    output logic [2:0] src_sel_q,
    output logic pll_ref_fast_q,
    output logic [4:0] osc_run_q,
    output logic pll_run_q,
    output logic [1:0] fast_freq_q,
    output logic freq_lock_trim_q,
    output logic busy_q
);
    localparam logic [TMR_W-1:0] PRE_CNT = TMR_W'(PRE_WAIT_CYC);
    localparam logic [TMR_W-1:0] POST_CNT = TMR_W'(POST_WAIT_CYC);

    ckc_tmr_if tif ();
    ckc_settle_timer u_tmr (
        .clk(clk),
        .rst(rst),
        .t(tif.tmr)
    );

    logic [3:0] div2_usb_q;
    logic [3:0] usbctrl_q;
    logic [4:0] osc_stop_q;
    logic pll_src_fast_q;
    ckc_seq_type seq_q;
    ckc_tgt_type tgt_q;
    logic [31:0] pend_q;
    logic start_d;
    logic [TMR_W-1:0] cyc_d;

    // true when any divider nibble grows
    function automatic logic any_raise(input logic [31:0] cur,
                                       input logic [31:0] nxt);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (nxt[i*4 +: 4] > cur[i*4 +: 4]) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    logic wr_div, wr_div2, wr_usb, wr_src;
    logic [31:0] cur_val;
    logic [31:0] new_val;
    ckc_tgt_type tgt_d;
    logic pre_need, post_need;

    always_comb begin
        wr_div = wr_stb && addr == OFS_SYS_CLK_DIV_CTRL;
        wr_div2 = wr_stb && addr == OFS_SYS_CLK_DIV_CTRL_SECOND;
        wr_usb = wr_stb && addr == OFS_USB_CLK_DIV_CTRL;
        wr_src = wr_stb && addr == OFS_SYS_CLK_SOURCE_SEL;
        cur_val = 32'h00000000;
        new_val = wdata;
        tgt_d = TGT_DIV;
        pre_need = 1'b0;
        post_need = 1'b0;
        if (wr_div) begin
            cur_val = sys_div_q;
        end else if (wr_div2) begin
            tgt_d = TGT_DIV2;
            cur_val = {24'h000000, div2_usb_q, 4'h0};
            new_val = {24'h000000, wdata[POS_USB_DIV_FIELD +: 4], 4'h0};
        end else if (wr_usb) begin
            tgt_d = TGT_USBDIV;
            cur_val = {28'h0000000, usbctrl_q};
            new_val = {28'h0000000, wdata[POS_USB_DIV_RATIO_FIELD +: 4]};
        end
        if (wr_src) begin
            tgt_d = TGT_SRC;
            pre_need = src_sel_q == SRC_PLL && wdata[2:0] != SRC_PLL; // [R16]
            post_need = src_sel_q != SRC_PLL && wdata[2:0] == SRC_PLL; // [R17]
        end else if (wr_div || wr_div2 || wr_usb) begin
            pre_need = any_raise(cur_val, new_val); // [R14]
            post_need = !pre_need && new_val != cur_val; // [R15]
        end
        start_d = 1'b0;
        cyc_d = POST_CNT;
        if (seq_q == SEQ_IDLE && (pre_need || post_need)) begin
            start_d = 1'b1;
            cyc_d = pre_need ? PRE_CNT : POST_CNT;
        end
    end

    assign tif.start = start_d;
    assign tif.cycles = cyc_d;

    logic change_wr;
    logic apply_now;
    logic [31:0] apply_val;
    ckc_tgt_type apply_tgt;

    always_comb begin
        change_wr = wr_div || wr_div2 || wr_usb || wr_src;
        // writes to switched registers are dropped while busy
        apply_now = change_wr && seq_q == SEQ_IDLE && !pre_need; // [R25]
        apply_val = new_val;
        apply_tgt = tgt_d;
        if (seq_q == SEQ_PRE && tif.done) begin
            apply_now = 1'b1;
            apply_val = pend_q;
            apply_tgt = tgt_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_q <= SEQ_IDLE;
            tgt_q <= TGT_DIV;
            pend_q <= 32'h00000000;
        end else begin
            case (seq_q)
                SEQ_IDLE: begin
                    if (change_wr && pre_need) begin
                        seq_q <= SEQ_PRE; // [R25]
                        tgt_q <= tgt_d;
                        pend_q <= new_val;
                    end else if (change_wr && post_need) begin
                        seq_q <= SEQ_POST;
                    end
                end
                SEQ_PRE, SEQ_POST: begin
                    if (tif.done) begin
                        seq_q <= SEQ_IDLE;
                    end
                end
                default: begin
                    seq_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_div_q <= RST_SYS_CLK_DIV_CTRL;
            div2_usb_q <= RST_USB_DIV;
            usbctrl_q <= RST_USB_DIV;
            src_sel_q <= RST_SRC; // [R23]
        end else if (apply_now) begin
            case (apply_tgt)
                TGT_DIV: begin
                    sys_div_q <= apply_val;
                end
                TGT_DIV2: begin
                    div2_usb_q <= apply_val[POS_USB_DIV_FIELD +: 4];
                end
                TGT_USBDIV: begin
                    usbctrl_q <= apply_val[3:0];
                end
                default: begin
                    // undefined source codes are ignored
                    if (apply_val[2:0] <= SRC_PLL) begin
                        src_sel_q <= apply_val[2:0];
                    end
                end
            endcase
        end
    end

    // oscillator stop bits: main, sub, fast, mid, slow
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_stop_q <= {2'h0, ~FAST_OSC_RESET_ON, 1'b1, 1'b1}; // [R24]
            fast_freq_q <= FAST_16MHZ;
        end else if (wr_stb) begin
            if (addr == OFS_MAIN_OSC_CTRL) begin
                osc_stop_q[0] <= wdata[POS_OSC_STOP]; // [R19]
            end else if (addr == OFS_SUB_OSC_CTRL) begin
                osc_stop_q[1] <= wdata[POS_OSC_STOP]; // [R19]
            end else if (addr == OFS_FAST_OSC_CTRL) begin
                osc_stop_q[2] <= wdata[POS_OSC_STOP]; // [R19]
                if (wdata[POS_FAST_FREQ +: 2] <= FAST_20MHZ) begin
                    fast_freq_q <= wdata[POS_FAST_FREQ +: 2]; // [R21]
                end
            end else if (addr == OFS_MID_OSC_CTRL) begin
                osc_stop_q[3] <= wdata[POS_OSC_STOP]; // [R19]
            end else if (addr == OFS_SLOW_OSC_CTRL) begin
                osc_stop_q[4] <= wdata[POS_OSC_STOP]; // [R19]
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdram_out_en_q <= 1'b0;
            freq_lock_trim_q <= 1'b0;
            pll_run_q <= 1'b0; // [R24]
            pll_src_fast_q <= 1'b0;
        end else if (wr_stb && addr == OFS_MISC_CTRL) begin
            sdram_out_en_q <= wdata[POS_SDRAM_EN];
            freq_lock_trim_q <= wdata[POS_TRIM_EN];
            pll_run_q <= wdata[POS_PLL_RUN];
            pll_src_fast_q <= wdata[POS_PLL_REF]; // [R22]
        end
    end

    // registered copies so every output leaves a flip-flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_run_q <= 5'h00;
            usb_div_q <= 4'h0;
            sdram_div_q <= 4'h0;
            pll_ref_fast_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            osc_run_q <= ~osc_stop_q;
            usb_div_q <= (VARIANT == 1) ? div2_usb_q : usbctrl_q; // [R7] [R8]
            sdram_div_q <= sys_div_q[POS_BUS_CLK +: 4]; // [R12]
            pll_ref_fast_q <= pll_src_fast_q; // [R22]
            busy_q <= seq_q != SEQ_IDLE; // [R25]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (rd_stb) begin
            if (addr == OFS_SYS_CLK_DIV_CTRL) begin
                rdata_q <= sys_div_q;
            end else if (addr == OFS_SYS_CLK_DIV_CTRL_SECOND) begin
                rdata_q <= {24'h000000, div2_usb_q, 4'h0};
            end else if (addr == OFS_USB_CLK_DIV_CTRL) begin
                rdata_q <= {28'h0000000, usbctrl_q};
            end else if (addr == OFS_SYS_CLK_SOURCE_SEL) begin
                rdata_q <= {29'h00000000, src_sel_q};
            end else if (addr == OFS_MAIN_OSC_CTRL) begin
                rdata_q <= {31'h00000000, osc_stop_q[0]};
            end else if (addr == OFS_SUB_OSC_CTRL) begin
                rdata_q <= {31'h00000000, osc_stop_q[1]};
            end else if (addr == OFS_FAST_OSC_CTRL) begin
                rdata_q <= {29'h00000000, fast_freq_q, osc_stop_q[2]};
            end else if (addr == OFS_MID_OSC_CTRL) begin
                rdata_q <= {31'h00000000, osc_stop_q[3]};
            end else if (addr == OFS_SLOW_OSC_CTRL) begin
                rdata_q <= {31'h00000000, osc_stop_q[4]};
            end else if (addr == OFS_MISC_CTRL) begin
                rdata_q <= {28'h0000000, pll_src_fast_q, pll_run_q,
                            freq_lock_trim_q, sdram_out_en_q};
            end else if (addr == OFS_STATUS) begin
                rdata_q <= {28'h0000000, tgt_q, seq_q};
            end else begin
                rdata_q <= 32'h00000000;
            end
        end else begin
            rdata_q <= 32'h00000000;
        end
    end
endmodule

// file: ckc_pkg.sv
package ckc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_SYS_CLK_DIV_CTRL = 8'h00;
    localparam logic [7:0] OFS_SYS_CLK_DIV_CTRL_SECOND = 8'h04;
    localparam logic [7:0] OFS_USB_CLK_DIV_CTRL = 8'h08;
    localparam logic [7:0] OFS_SYS_CLK_SOURCE_SEL = 8'h0c;
    localparam logic [7:0] OFS_MAIN_OSC_CTRL = 8'h10;
    localparam logic [7:0] OFS_SUB_OSC_CTRL = 8'h14;
    localparam logic [7:0] OFS_FAST_OSC_CTRL = 8'h18;
    localparam logic [7:0] OFS_MID_OSC_CTRL = 8'h1c;
    localparam logic [7:0] OFS_SLOW_OSC_CTRL = 8'h20;
    localparam logic [7:0] OFS_MISC_CTRL = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;

    // sys_clk_div_ctrl nibble positions, code n means divide by 2**n, then field bit positions of the other registers
    localparam int POS_PCLK_D = 0;
    localparam int POS_PCLK_C = 4;
    localparam int POS_PCLK_B = 8;
    localparam int POS_PCLK_A = 12;
    localparam int POS_BUS_CLK = 16;
    localparam int POS_ETH_CLK = 20;
    localparam int POS_CORE_CLK = 24;
    localparam int POS_FLASH_CLK = 28;
    localparam int POS_USB_DIV_FIELD = 4;
    localparam int POS_USB_DIV_RATIO_FIELD = 0;
    localparam int POS_OSC_STOP = 0;
    localparam int POS_FAST_FREQ = 1;
    localparam int POS_SDRAM_EN = 0;
    localparam int POS_TRIM_EN = 1;
    localparam int POS_PLL_RUN = 2;
    localparam int POS_PLL_REF = 3;

    // reset values
    localparam logic [31:0] RST_SYS_CLK_DIV_CTRL = 32'h22022222;
    localparam logic [3:0] RST_USB_DIV = 4'h4;
    localparam logic [2:0] RST_SRC = 3'h1;

    // source select codes
    localparam logic [2:0] SRC_FAST_OSC = 3'h0;
    localparam logic [2:0] SRC_MID_OSC = 3'h1;
    localparam logic [2:0] SRC_SLOW_OSC = 3'h2;
    localparam logic [2:0] SRC_MAIN_OSC = 3'h3;
    localparam logic [2:0] SRC_SUB_OSC = 3'h4;
    localparam logic [2:0] SRC_PLL = 3'h5;

    // fast_onchip_osc frequency select: 16, 18, 20 MHz
    localparam logic [1:0] FAST_16MHZ = 2'h0;
    localparam logic [1:0] FAST_18MHZ = 2'h1;
    localparam logic [1:0] FAST_20MHZ = 2'h2;

    // settling times
    localparam int CLK_MHZ = 50;
    localparam int PRE_WAIT_NS = 750;
    localparam int POST_WAIT_NS = 250;
    localparam int PRE_WAIT_CYC = (PRE_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int POST_WAIT_CYC = (POST_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 6;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_PRE = 2'b01,
        SEQ_POST = 2'b10
    } ckc_seq_type;

    typedef enum logic [1:0] {
        TGT_DIV = 2'b00,
        TGT_DIV2 = 2'b01,
        TGT_USBDIV = 2'b10,
        TGT_SRC = 2'b11
    } ckc_tgt_type;
endpackage

// file: ckc_tmr_if.sv
`timescale 1ns/1ns
interface ckc_tmr_if import ckc_pkg::*; ();
    logic start;
    logic [TMR_W-1:0] cycles;
    logic done;
    modport ctrl (output start, output cycles, input done);
    modport tmr (input start, input cycles, output done);
endinterface

// file: ckc_settle_timer.sv
`timescale 1ns/1ns
module ckc_settle_timer import ckc_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    ckc_tmr_if.tmr t
);
    logic [TMR_W-1:0] cnt_q;
    logic run_q;
    logic done_q;

    assign t.done = done_q;

    // done pulses exactly cycles edges after the start pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 6'h00;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (t.start) begin
                cnt_q <= t.cycles - 6'h01;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q == 6'h01 || cnt_q == 6'h00) begin
                    run_q <= 1'b0;
                    done_q <= 1'b1;
                end
                cnt_q <= cnt_q - 6'h01;
            end
        end
    end
endmodule

// file: ckc_clock_ctrl_asserts.sv
`timescale 1ns/1ns
module ckc_clock_ctrl_asserts import ckc_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic [31:0] sys_div_q,
    input wire logic [3:0] sdram_div_q,
    input wire logic [2:0] src_sel_q,
    input wire logic pll_ref_fast_q,
    input wire logic [4:0] osc_run_q,
    input wire logic pll_run_q,
    input wire logic [1:0] fast_freq_q,
    input wire logic busy_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] bcnt_q;
    logic up;
    assign up = wr_stb && addr == OFS_SYS_CLK_DIV_CTRL && !busy_q
        && wdata[27:24] > sys_div_q[27:24];
    // busy run length; the longer settling wait is the upper bound
    always_ff @(posedge clk or posedge rst) begin
        if (rst) bcnt_q <= 8'h00;
        else bcnt_q <= busy_q ? bcnt_q + 8'h01 : 8'h00;
    end
    property p_sdram;
        !$past(rst) |-> sdram_div_q == $past(sys_div_q[19:16]);
    endproperty
    property p_hold;
        up |-> ##2 busy_q && sys_div_q == $past(sys_div_q, 2);
    endproperty
    property p_apply;
        busy_q && $changed(sys_div_q) |=> !busy_q;
    endproperty
    property p_len;
        bcnt_q <= PRE_WAIT_CYC;
    endproperty
    property p_main;
        wr_stb && addr == OFS_MAIN_OSC_CTRL |->
            ##2 osc_run_q[0] == !$past(wdata[0], 2);
    endproperty
    property p_mid;
        wr_stb && addr == OFS_MID_OSC_CTRL |->
            ##2 osc_run_q[3] == !$past(wdata[0], 2);
    endproperty
    property p_freq;
        fast_freq_q != 2'h3;
    endproperty
    property p_ref;
        wr_stb && addr == OFS_MISC_CTRL |->
            ##2 pll_ref_fast_q == $past(wdata[3], 2);
    endproperty
    property p_rsrc;
        $fell(rst) |-> src_sel_q == SRC_MID_OSC
            && sys_div_q == RST_SYS_CLK_DIV_CTRL;
    endproperty
    property p_roff;
        $fell(rst) |-> !pll_run_q ##1 osc_run_q[1:0] == 2'b00;
    endproperty
    a_sdram: assert property (p_sdram) else $error("sdram div");
    a_hold: assert property (p_hold) else $error("raise held");
    a_apply: assert property (p_apply) else $error("busy end");
    a_len: assert property (p_len) else $error("busy length");
    a_main: assert property (p_main) else $error("main osc");
    a_mid: assert property (p_mid) else $error("mid osc");
    a_freq: assert property (p_freq) else $error("fast freq");
    a_ref: assert property (p_ref) else $error("pll ref");
    a_rsrc: assert property (p_rsrc) else $error("reset src");
    a_roff: assert property (p_roff) else $error("reset off");
    c_up: cover property (up);
    c_pll: cover property (src_sel_q == SRC_PLL);
    c_stop: cover property (!osc_run_q[3]);
endmodule
bind ckc_clock_ctrl ckc_clock_ctrl_asserts u_chk (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .sys_div_q(sys_div_q),
    .sdram_div_q(sdram_div_q), .src_sel_q(src_sel_q),
    .pll_ref_fast_q(pll_ref_fast_q), .osc_run_q(osc_run_q),
    .pll_run_q(pll_run_q), .fast_freq_q(fast_freq_q), .busy_q(busy_q));

// file: ckc_clock_ctrl_tb_top.sv
`timescale 1ns/1ns
module ckc_clock_ctrl_tb_top import ckc_pkg::*; ();
    logic clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata_q, sys_div_q;
    logic [3:0] usb_div_q, sdram_div_q;
    logic [2:0] src_sel_q;
    logic [4:0] osc_run_q;
    logic [1:0] fast_freq_q;
    logic sdram_out_en_q, pll_ref_fast_q, pll_run_q, freq_lock_trim_q;
    logic busy_q;
    int err_count = 0;
    int n_compared = 0;
    logic [31:0] lfsr_q = 32'h53;
    logic [31:0] div_m = RST_SYS_CLK_DIV_CTRL;
    logic [2:0] src_m = RST_SRC;
    always #10 clk = ~clk;
    ckc_clock_ctrl #(.VARIANT(1), .FAST_OSC_RESET_ON(1'b0)) uut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q),
        .sys_div_q(sys_div_q), .usb_div_q(usb_div_q),
        .sdram_div_q(sdram_div_q), .sdram_out_en_q(sdram_out_en_q),
        .src_sel_q(src_sel_q), .pll_ref_fast_q(pll_ref_fast_q),
        .osc_run_q(osc_run_q), .pll_run_q(pll_run_q),
        .fast_freq_q(fast_freq_q), .freq_lock_trim_q(freq_lock_trim_q),
        .busy_q(busy_q));
    logic [3:0] usb_div_v2;
    logic [4:0] osc_run_v2;
    // second variant, fast oscillator running from reset
    ckc_clock_ctrl #(.VARIANT(2), .FAST_OSC_RESET_ON(1'b1)) uut_v2 (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(),
        .sys_div_q(), .usb_div_q(usb_div_v2),
        .sdram_div_q(), .sdram_out_en_q(),
        .src_sel_q(), .pll_ref_fast_q(),
        .osc_run_q(osc_run_v2), .pll_run_q(),
        .fast_freq_q(), .freq_lock_trim_q(),
        .busy_q());
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk("rdata", rdata_q, e);
        tick(1);
        chk("rdata idle", rdata_q, 32'h0);
    endtask
    function automatic int dkind(input logic [31:0] o, n);
        int r = 0;
        for (int i = 0; i < 32; i += 4) begin
            if (n[i+:4] > o[i+:4]) r = 1;
            else if (n[i+:4] < o[i+:4] && r == 0) r = 2;
        end
        return r;
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], ^(s & 32'h80200003)};
    endfunction
    // software duties: bus never faster than core, ethernet equal to
    // core, medium clocks at most half of core, flash kept fast
    function automatic logic [31:0] sw_legal(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (r[19:16] < r[27:24]) r[19:16] = r[27:24];
        r[23:20] = r[27:24];
        if (r[11:8] <= r[27:24]) r[11:8] = r[27:24] + 4'h1;
        if (r[7:4] <= r[27:24]) r[7:4] = r[27:24] + 4'h1;
        if (r[31:28] > 4'h3) r[31:28] = 4'h3;
        return r;
    endfunction
    function automatic logic [31:0] obs(input bit t);
        return t ? {29'h0, src_sel_q} : sys_div_q;
    endfunction
    // k: 0 immediate, 1 held for the long wait, 2 applied then short wait
    task automatic seq(input bit t, input logic [31:0] d, input int k);
        int n;
        int b;
        wr(t ? OFS_SYS_CLK_SOURCE_SEL : OFS_SYS_CLK_DIV_CTRL, d);
        // a second change while pending must be dropped
        if (k == 1) wr(t ? OFS_SYS_CLK_SOURCE_SEL : OFS_SYS_CLK_DIV_CTRL,
            d ^ 32'h11111111);
        #1;
        // counted from the first write edge; the dropped write took two
        for (n = k == 1 ? 2 : 0; n < 60 && obs(t) !== d; n++) begin
            tick(1);
        end
        chk("apply cycle", n, k == 1 ? PRE_WAIT_CYC : 0);
        // software waits by counting cycles until the block idles
        for (b = n; b < 80 && (b == 0 || busy_q !== 1'b0); b++) begin
            tick(1);
        end
        chk("busy end", b, k == 0 ? 1 : 1 + (k == 1 ? PRE_WAIT_CYC
            : POST_WAIT_CYC));
        chk("settled", obs(t), d);
        if (n >= 60 || b >= 80) final_report();
    endtask
    initial begin
        int i;
        int k;
        logic [31:0] v;
        logic [2:0] srcs [0:6] = '{3'h5, 3'h3, 3'h5, 3'h0, 3'h4, 3'h2, 3'h1};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset src", src_sel_q, SRC_MID_OSC);
        chk("reset div", sys_div_q, RST_SYS_CLK_DIV_CTRL);
        chk("reset pll", pll_run_q, 1'b0);
        tick(1);
        chk("reset osc", osc_run_q, 5'h18);
        chk("reset osc v2", osc_run_v2, 5'h1c);
        chk("reset usb", usb_div_q, RST_USB_DIV);
        rd(8'h40, 32'h0);
        for (i = 0; i < 6; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            v = i[0] ? div_m & lfsr_q : lfsr_q & 32'h77777777;
            if (i == 4) v = div_m;
            v = sw_legal(v);
            seq(1'b0, v, dkind(div_m, v));
            div_m = v;
            chk("sdram div", sdram_div_q, div_m[19:16]);
        end
        rd(OFS_SYS_CLK_DIV_CTRL, div_m);
        for (i = 0; i < 7; i++) begin
            k = (src_m == SRC_PLL) == (srcs[i] == SRC_PLL) ? 0
                : (srcs[i] == SRC_PLL ? 2 : 1);
            seq(1'b1, {29'h0, srcs[i]}, k);
            src_m = srcs[i];
        end
        rd(OFS_SYS_CLK_SOURCE_SEL, {29'h0, src_m});
        wr(OFS_SYS_CLK_SOURCE_SEL, 32'h6);
        tick(2);
        chk("bad source", src_sel_q, src_m);
        wr(OFS_SYS_CLK_DIV_CTRL_SECOND, 32'h20);
        tick(20);
        chk("usb div", usb_div_q, 4'h2);
        chk("usb div v2 kept", usb_div_v2, RST_USB_DIV);
        wr(OFS_USB_CLK_DIV_CTRL, 32'h1);
        tick(20);
        chk("usb div kept", usb_div_q, 4'h2);
        chk("usb div v2", usb_div_v2, 4'h1);
        for (i = 0; i < 5; i++) wr(OFS_MAIN_OSC_CTRL + 8'(4 * i), 32'h0);
        tick(2);
        chk("osc run", osc_run_q, 5'h1f);
        for (i = 0; i < 5; i++) begin
            wr(OFS_MAIN_OSC_CTRL + 8'(4 * i), 32'h1);
            tick(2);
            chk("osc stop", osc_run_q, 5'h1f ^ (5'h1 << i));
            wr(OFS_MAIN_OSC_CTRL + 8'(4 * i), 32'h0);
        end
        v = 32'h0;
        for (i = 1; i < 5; i++) begin
            wr(OFS_FAST_OSC_CTRL, 32'(i % 4) << 1);
            if (i != 3) v = 32'(i % 4);
            tick(2);
            chk("fast freq", fast_freq_q, v[1:0]);
        end
        for (i = 0; i < 2; i++) begin
            wr(OFS_MISC_CTRL, i == 0 ? 32'hf : 32'h0);
            tick(2);
            chk("misc", {sdram_out_en_q, freq_lock_trim_q, pll_run_q,
                pll_ref_fast_q}, i == 0 ? 4'hf : 4'h0);
        end
        // a mid-run reset must bring back the start-up clocking
        seq(1'b1, {29'h0, SRC_PLL}, 2);
        wr(OFS_MISC_CTRL, 32'h4);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("rerun src", src_sel_q, SRC_MID_OSC);
        chk("rerun pll", pll_run_q, 1'b0);
        tick(1);
        chk("rerun osc", osc_run_q, 5'h18);
        chk("rerun osc v2", osc_run_v2, 5'h1c);
        final_report();
    end
endmodule
